// >>> rtl/sfb_pkg.sv
// Constants and types for the serial flash bus front end
// Assumes a single 20 MHz system clock sampling all pins
package sfb_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS        = 50;
  localparam int unsigned RESTART_PULSE_MIN_NS = 1000;
  localparam int unsigned RESTART_PULSE_CYC    =
    (RESTART_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0]  RST_CNT_MAX          = 6'(RESTART_PULSE_CYC);

  // ---------------------------------------------------------------
  // Command codes that widen the data path
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_DUAL_OUT   = 8'h3b;
  localparam logic [7:0] CMD_DUAL_OUT4  = 8'h3c;
  localparam logic [7:0] CMD_DUAL_IO    = 8'hbb;
  localparam logic [7:0] CMD_DUAL_IO4   = 8'hbc;
  localparam logic [7:0] CMD_QUAD_OUT   = 8'h6b;
  localparam logic [7:0] CMD_QUAD_OUT4  = 8'h6c;
  localparam logic [7:0] CMD_QUAD_IO    = 8'heb;
  localparam logic [7:0] CMD_QUAD_IO4   = 8'hec;

  // ---------------------------------------------------------------
  // Reset values and field widths
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_RST        = 8'h00;
  localparam logic [2:0] BITCNT_RST     = 3'h0;
  localparam logic [3:0] TXSHF_RST      = 4'h0;
  localparam logic [2:0] SYNC_W         = 3'h4;

  // ---------------------------------------------------------------
  // Lane width of the data phase
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SFB_LANE_1 = 2'b00,
    SFB_LANE_2 = 2'b01,
    SFB_LANE_4 = 2'b10
  } sfb_lane_t;

  // ---------------------------------------------------------------
  // Transfer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SFB_IDLE  = 2'b00,
    SFB_OPC   = 2'b01,
    SFB_DATA  = 2'b10,
    SFB_PAUSE = 2'b11
  } sfb_state_t;

endpackage : sfb_pkg

// >>> rtl/sfb_sync.sv
// Two-stage synchroniser bank for asynchronous pin inputs
// Assumes pins are asynchronous to clk; output lags by two edges
`timescale 1ns/1ps
module sfb_sync
  import sfb_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // ---------------------------------------------------------------
  // Per-bit stages
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_comb begin
        nxt_meta[gi] = din[gi];
        nxt_sync[gi] = meta_ff[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;

endmodule // sfb_sync

// >>> rtl/sfb_front_end.sv
// Serial flash bus front end: pin sampling, lanes, pause, reset
// Assumes a 20 MHz clk far faster than the serial clock it samples
//
// Functional notes
// - Capture input bits on rising serial clock, change outputs on falling.
// - Work with host clock mode 0 or mode 3.
// - Dual read commands drive and sample two lines per clock.
// - Quad read commands drive and sample all four lines per clock.
// - Quad commands honoured only while wide-I/O enable is set.
// - Shared pin is active-low pause when pin-function select is 0.
// - Wide-I/O enable set disables pause and shared reset.
// - Pause suspends the link; internal operations keep running.
// - Pause starts on pause fall with select low, deferred to clock low.
// - Pause ends on pause rise, deferred until clock is low.
// - While paused, output floats; data and clock are ignored.
// - Select rising while paused resets interface logic.
// - Shared pin is active-low reset when pin-function select is 1.
// - Dedicated reset pin works regardless of any setting.
// - Reset taken when reset held low for at least 1 us.
// - After reset, standby with volatile bits at power-on values.
// - Dedicated reset ignores configuration and ongoing operation.
`timescale 1ns/1ps
module sfb_front_end
  import sfb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe,
  input  wire logic       dedicated_rst_n,
  input  wire logic       wide_io_enable,
  input  wire logic       pin_func_rst,
  input  wire logic [3:0] tx_nibble,
  output logic            tx_take,
  output logic      [7:0] opcode,
  output logic            opcode_valid,
  output logic      [3:0] rx_nibble,
  output logic            rx_valid,
  output logic      [1:0] lane_mode,
  output logic            paused,
  output logic            link_abort,
  output logic            hw_reset,
  output logic            tx_enable
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_s;
  logic [3:0] io_s;
  logic       sclk_s;
  logic       sel_n_s;
  logic       drst_n_s;

  sfb_sync #(.W(4)) u_sync_ctl (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({sclk, sel_n, dedicated_rst_n, 1'b1}),
    .dout    (pin_s)
  );

  sfb_sync #(.W(4)) u_sync_io (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (io_i),
    .dout    (io_s)
  );

  assign sclk_s   = pin_s[3];
  assign sel_n_s  = pin_s[2];
  assign drst_n_s = pin_s[1];

  // ---------------------------------------------------------------
  // Shared pin function
  // ---------------------------------------------------------------
  logic pause_n_s;
  logic shrst_n_s;
  // Shared pin acts as data only when wide I/O is on
  assign pause_n_s = wide_io_enable | pin_func_rst | io_s[3];
  assign shrst_n_s = wide_io_enable | ~pin_func_rst | io_s[3];

  // ---------------------------------------------------------------
  // Hardware reset pulse filter
  // ---------------------------------------------------------------
  logic [5:0] rcnt_ff;
  logic [5:0] nxt_rcnt;
  logic       hwr_ff;
  logic       nxt_hwr;
  logic       rst_low;

  // Dedicated pin never gated by settings
  assign rst_low = ~drst_n_s | ~shrst_n_s;

  always_comb begin
    nxt_rcnt = rcnt_ff;
    nxt_hwr  = 1'b0;
    if (!rst_low) begin
      nxt_rcnt = '0;
    end else if (rcnt_ff < RST_CNT_MAX) begin
      nxt_rcnt = rcnt_ff + 6'h01;
    end
    if (rst_low && rcnt_ff == RST_CNT_MAX - 6'h01) begin
      nxt_hwr = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rcnt_ff <= '0;
      hwr_ff  <= 1'b0;
    end else begin
      rcnt_ff <= nxt_rcnt;
      hwr_ff  <= nxt_hwr;
    end
  end

  assign hw_reset = hwr_ff;

  // ---------------------------------------------------------------
  // Transfer state machine
  // ---------------------------------------------------------------
  sfb_state_t state_ff;
  sfb_state_t nxt_state;
  logic       sclk_d_ff;
  logic       sel_n_d_ff;
  logic       pause_n_d_ff;
  logic [7:0] opc_ff;
  logic [7:0] nxt_opc;
  logic [2:0] bcnt_ff;
  logic [2:0] nxt_bcnt;
  sfb_lane_t  lane_ff;
  sfb_lane_t  nxt_lane;
  logic [3:0] tx_ff;
  logic [3:0] nxt_tx;
  logic [3:0] rx_ff;
  logic [3:0] nxt_rx;
  logic       rxv_ff;
  logic       nxt_rxv;
  logic       opv_ff;
  logic       nxt_opv;
  logic       abort_ff;
  logic       nxt_abort;
  logic       pause_req_ff;
  logic       nxt_pause_req;
  logic       resume_data_ff;
  logic       nxt_resume_data;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       link_rst;

  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;
  assign link_rst  = sys_rst | hwr_ff;

  function automatic sfb_lane_t lane_of(input logic [7:0] c,
                                        input logic qe);
    sfb_lane_t l;
    l = SFB_LANE_1;
    if (c == CMD_DUAL_OUT || c == CMD_DUAL_OUT4 ||
        c == CMD_DUAL_IO  || c == CMD_DUAL_IO4) begin
      l = SFB_LANE_2;
    end
    if (qe && (c == CMD_QUAD_OUT || c == CMD_QUAD_OUT4 ||
               c == CMD_QUAD_IO  || c == CMD_QUAD_IO4)) begin
      l = SFB_LANE_4;
    end
    return l;
  endfunction

  always_comb begin
    nxt_state     = state_ff;
    nxt_opc       = opc_ff;
    nxt_bcnt      = bcnt_ff;
    nxt_lane      = lane_ff;
    nxt_tx        = tx_ff;
    nxt_rx        = rx_ff;
    nxt_rxv       = 1'b0;
    nxt_opv       = 1'b0;
    nxt_abort     = 1'b0;
    nxt_pause_req = pause_req_ff;
    nxt_resume_data = resume_data_ff;
    // Pause fall latched, entry waits for clock low
    if (pause_n_d_ff && !pause_n_s && !sel_n_s) begin
      nxt_pause_req = 1'b1;
    end
    if (pause_n_s) begin
      nxt_pause_req = 1'b0;
    end
    case (state_ff)
      SFB_IDLE: begin
        nxt_lane = SFB_LANE_1;
        nxt_bcnt = BITCNT_RST;
        if (sel_n_d_ff && !sel_n_s) begin
          nxt_state = SFB_OPC;
          nxt_opc   = OPC_RST;
        end
      end
      SFB_OPC, SFB_DATA: begin
        if (sel_n_s) begin
          nxt_state = SFB_IDLE;
        end else if (pause_req_ff && !sclk_s) begin
          nxt_state = SFB_PAUSE;
          nxt_resume_data = (state_ff == SFB_DATA);
        end else if (sclk_rise) begin
          if (state_ff == SFB_OPC) begin
            nxt_opc  = {opc_ff[6:0], io_s[0]};
            nxt_bcnt = bcnt_ff + 3'h1;
            if (bcnt_ff == 3'h7) begin
              nxt_state = SFB_DATA;
              nxt_opv   = 1'b1;
              nxt_lane  = lane_of({opc_ff[6:0], io_s[0]},
                                  wide_io_enable);
            end
          end else begin
            nxt_rxv = 1'b1;
            case (lane_ff)
              SFB_LANE_4: nxt_rx = io_s;
              SFB_LANE_2: nxt_rx = {2'b00, io_s[1:0]};
              default:    nxt_rx = {3'b000, io_s[0]};
            endcase
          end
        end else if (sclk_fall && state_ff == SFB_DATA) begin
          nxt_tx = tx_nibble;
        end
      end
      SFB_PAUSE: begin
        // Clock and data ignored here
        if (sel_n_s) begin
          nxt_state = SFB_IDLE;
          nxt_abort = 1'b1;
        end else if (pause_n_s && !sclk_s) begin
          nxt_state = resume_data_ff ? SFB_DATA : SFB_OPC;
        end
      end
      default: nxt_state = SFB_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (link_rst) begin
      state_ff     <= SFB_IDLE;
      sclk_d_ff    <= 1'b0;
      sel_n_d_ff   <= 1'b0;
      pause_n_d_ff <= 1'b1;
      opc_ff       <= OPC_RST;
      bcnt_ff      <= BITCNT_RST;
      lane_ff      <= SFB_LANE_1;
      tx_ff        <= TXSHF_RST;
      rx_ff        <= TXSHF_RST;
      rxv_ff       <= 1'b0;
      opv_ff       <= 1'b0;
      abort_ff     <= 1'b0;
      pause_req_ff <= 1'b0;
      resume_data_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      sclk_d_ff    <= sclk_s;
      sel_n_d_ff   <= sel_n_s;
      pause_n_d_ff <= pause_n_s;
      opc_ff       <= nxt_opc;
      bcnt_ff      <= nxt_bcnt;
      lane_ff      <= nxt_lane;
      tx_ff        <= nxt_tx;
      rx_ff        <= nxt_rx;
      rxv_ff       <= nxt_rxv;
      opv_ff       <= nxt_opv;
      abort_ff     <= nxt_abort;
      pause_req_ff <= nxt_pause_req;
      resume_data_ff <= nxt_resume_data;
    end
  end

  // ---------------------------------------------------------------
  // Outputs and pin drive
  // ---------------------------------------------------------------
  always_comb begin
    io_oe = 4'h0;
    if (state_ff == SFB_DATA && tx_enable) begin
      case (lane_ff)
        SFB_LANE_4: io_oe = 4'hf;
        SFB_LANE_2: io_oe = 4'h3;
        default:    io_oe = 4'h2;
      endcase
    end
  end

  assign io_o         = (lane_ff == SFB_LANE_1) ? {2'b00, tx_ff[0], 1'b0}
                                                : tx_ff;
  assign tx_take      = (state_ff == SFB_DATA) & sclk_fall;
  assign tx_enable    = ~sel_n_s;
  assign opcode       = opc_ff;
  assign opcode_valid = opv_ff;
  assign rx_nibble    = rx_ff;
  assign rx_valid     = rxv_ff;
  assign lane_mode    = lane_ff;
  assign paused       = (state_ff == SFB_PAUSE);
  assign link_abort   = abort_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_rst_held;
    rst_low [*8];
  endsequence

  a_pause_floats: assert property (@(posedge clk) disable iff (link_rst)
    (state_ff == SFB_PAUSE) |-> io_oe == 4'h0)
    else $error("lines driven while paused");

  a_sel_high_float: assert property (@(posedge clk) disable iff (link_rst)
    (state_ff == SFB_IDLE) |-> io_oe == 4'h0)
    else $error("lines driven while idle");

  a_abort_on_sel: assert property (@(posedge clk) disable iff (link_rst)
    (state_ff == SFB_PAUSE && sel_n_s) |=> link_abort && !paused)
    else $error("select rise in pause did not abort");

  a_pause_entry_low: assert property (@(posedge clk) disable iff (link_rst)
    $rose(paused) |-> !$past(sclk_s))
    else $error("pause entered with clock high");

  a_pause_exit_low: assert property (@(posedge clk) disable iff (link_rst)
    $fell(paused) && !link_abort |-> !$past(sclk_s) && $past(pause_n_s))
    else $error("pause left with clock high");

  a_quad_needs_qe: assert property (@(posedge clk) disable iff (link_rst)
    $rose(opcode_valid) && lane_mode == SFB_LANE_4 |-> wide_io_enable)
    else $error("quad lane without wide-io enable");

  a_qe_no_pause: assert property (@(posedge clk) disable iff (link_rst)
    wide_io_enable [*3] |-> !$rose(pause_req_ff))
    else $error("pause armed while wide-io enabled");

  a_reset_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    hw_reset |-> $past(rcnt_ff) == RST_CNT_MAX - 6'h01)
    else $error("reset pulse taken too early");

  a_reset_min: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(rst_low) ##1 !rst_low |-> ##[0:2] !hw_reset)
    else $error("short reset glitch taken");

  a_reset_idle: assert property (@(posedge clk) disable iff (sys_rst)
    hw_reset |=> state_ff == SFB_IDLE && !opcode_valid)
    else $error("state not standby after reset");

  a_reset_taken: assert property (@(posedge clk) disable iff (link_rst)
    $rose(rst_low) ##1 s_rst_held |-> ##[1:25] (hw_reset || !rst_low))
    else $error("held reset not acted on");

endmodule // sfb_front_end

// >>> verif/sfb_host_model.sv
// Host flash controller model: serial clock, select, data, reset pins
// Assumes the bench clock; pins change only by NBA at its rising edge
`timescale 1ns/1ps
module sfb_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] dev_o,
  input  wire logic [3:0] dev_oe,
  output logic            sclk,
  output logic            sel_n,
  output logic            dedicated_rst_n,
  output logic      [3:0] io_wire
);
  // ---------------------------------------------------------------
  // Pin state
  // ---------------------------------------------------------------
  logic       idle_hi;
  logic [3:0] drv;
  logic       float_bit;

  initial begin
    sclk            = 1'b0;
    sel_n           = 1'b1;
    dedicated_rst_n = 1'b1;
    drv             = 4'hd;
    idle_hi         = 1'b0;
    float_bit       = 1'b0;
  end

  // Released serial out toggles every cycle
  always @(posedge clk) begin
    float_bit <= ~float_bit;
  end

  // Device drive wins per line
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      io_wire[b] = dev_oe[b] ? dev_o[b] : drv[b];
    end
    if (!dev_oe[1]) begin
      io_wire[1] = float_bit;
    end
  end

  // ---------------------------------------------------------------
  // Host operations
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Select fall with clock parked at the mode idle level
  task automatic start(input logic mode3);
    idle_hi <= mode3;
    sclk    <= mode3;
    tick(4);
    sel_n   <= 1'b0;
    tick(4);
  endtask

  // Low n bits of b, MSB first, data set while clock low
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sclk   <= 1'b0;
      drv[0] <= b[i];
      tick(4);
      sclk   <= 1'b1;
      tick(4);
    end
  endtask

  // Clock back to idle, then select high
  task automatic stop();
    sclk  <= idle_hi;
    tick(4);
    sel_n <= 1'b1;
    tick(4);
  endtask

  // Direct pin levels for pause and reset sequences
  task automatic pins(input logic c, input logic s, input logic p3,
                      input logic r, input int n);
    sclk            <= c;
    sel_n           <= s;
    drv[3]          <= p3;
    dedicated_rst_n <= r;
    tick(n);
  endtask
endmodule // sfb_host_model

// >>> verif/testbench.sv
// Self-checking bench for the serial flash bus front end
// Assumes the host model drives all pins; 20 MHz bench clock
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench
  import sfb_pkg::*;
;
  localparam int TIMEOUT_CYC = 12000;
  logic       clk, sys_rst, wide_io_enable, pin_func_rst;
  logic [3:0] tx_nibble, io_o, io_oe, io_wire, rx_nibble;
  logic       sclk, sel_n, dedicated_rst_n, paused, link_abort;
  logic       hw_reset, tx_enable, tx_take, opcode_valid, rx_valid;
  logic [7:0] opcode;
  logic [1:0] lane_mode;
  int         n_errors, checks, n_abort, n_hwrst, cyc;
  int         n_opv, n_take, n_rxv;

  sfb_front_end i_sfb_front_end (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .sel_n(sel_n),
    .io_i(io_wire), .io_o(io_o), .io_oe(io_oe),
    .dedicated_rst_n(dedicated_rst_n), .wide_io_enable(wide_io_enable),
    .pin_func_rst(pin_func_rst), .tx_nibble(tx_nibble),
    .tx_take(tx_take), .opcode(opcode), .opcode_valid(opcode_valid),
    .rx_nibble(rx_nibble), .rx_valid(rx_valid),
    .lane_mode(lane_mode), .paused(paused), .link_abort(link_abort),
    .hw_reset(hw_reset), .tx_enable(tx_enable));

  sfb_host_model i_sfb_host_model (
    .clk(clk), .dev_o(io_o), .dev_oe(io_oe), .sclk(sclk), .sel_n(sel_n),
    .dedicated_rst_n(dedicated_rst_n), .io_wire(io_wire));

  always #25 clk = ~clk;

  // ---------------------------------------------------------------
  // Pulse counters and cycle limit
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (link_abort === 1'b1) n_abort++;
    if (hw_reset === 1'b1) n_hwrst++;
    if (opcode_valid === 1'b1) n_opv++;
    if (tx_take === 1'b1) n_take++;
    if (rx_valid === 1'b1) n_rxv++;
    if (cyc == TIMEOUT_CYC) begin
      n_errors++;
      $display("Error cycle limit expected %0d seen %0d", 0, cyc);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_mode(input logic mode3);
    int n0, t0, r0;
    n0 = n_opv;
    t0 = n_take;
    r0 = n_rxv;
    i_sfb_host_model.start(mode3);
    `CHK("tx_enable", 1'b1, tx_enable)
    i_sfb_host_model.send_bits(8'h03, 8);
    i_sfb_host_model.tick(2);
    `CHK("opcode", 8'h03, opcode)
    `CHK("opcode_valid", n0 + 1, n_opv)
    `CHK("lane_mode", SFB_LANE_1, lane_mode)
    tx_nibble <= 4'hf;
    i_sfb_host_model.send_bits(8'h01, 1);
    `CHK("io_oe", 4'h2, io_oe)
    `CHK("io1 high", 1'b1, io_o[1])
    `CHK("rx_nibble", 4'h1, rx_nibble)
    tx_nibble <= 4'h0;
    i_sfb_host_model.send_bits(8'h00, 1);
    i_sfb_host_model.tick(2);
    `CHK("io1 low", 1'b0, io_o[1])
    `CHK("tx_take", t0 + 2, n_take)
    `CHK("rx_valid", r0 + 2, n_rxv)
    i_sfb_host_model.stop();
    `CHK("io_oe idle", 4'h0, io_oe)
    $display("t_mode %0d done", mode3);
  endtask

  task automatic t_lanes();
    logic [7:0] codes [8];
    logic [3:0] oe;
    codes = '{CMD_DUAL_OUT, CMD_DUAL_OUT4, CMD_DUAL_IO, CMD_DUAL_IO4,
              CMD_QUAD_OUT, CMD_QUAD_OUT4, CMD_QUAD_IO, CMD_QUAD_IO4};
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 8; i++) begin
        wide_io_enable <= w[0];
        oe = (i < 4) ? 4'h3 : (w == 1) ? 4'hf : 4'h2;
        i_sfb_host_model.start(1'b0);
        i_sfb_host_model.send_bits(codes[i], 8);
        tx_nibble <= 4'ha;
        i_sfb_host_model.send_bits(8'h00, 1);
        `CHK("io_oe", oe, io_oe)
        if (oe == 4'hf) `CHK("io_o quad", 4'ha, io_o)
        i_sfb_host_model.stop();
      end
    end
    $display("t_lanes done");
  endtask

  task automatic t_pause();
    wide_io_enable <= 1'b0;
    pin_func_rst   <= 1'b0;
    i_sfb_host_model.start(1'b0);
    i_sfb_host_model.send_bits(8'h0a, 4);
    i_sfb_host_model.pins(1'b1, 1'b0, 1'b0, 1'b1, 6);
    `CHK("paused early", 1'b0, paused)
    i_sfb_host_model.pins(1'b0, 1'b0, 1'b0, 1'b1, 6);
    `CHK("paused", 1'b1, paused)
    i_sfb_host_model.send_bits(8'h07, 3);
    i_sfb_host_model.pins(1'b1, 1'b0, 1'b1, 1'b1, 6);
    `CHK("paused held", 1'b1, paused)
    i_sfb_host_model.pins(1'b0, 1'b0, 1'b1, 1'b1, 6);
    `CHK("resumed", 1'b0, paused)
    i_sfb_host_model.send_bits(8'h05, 4);
    i_sfb_host_model.send_bits(8'h00, 1);
    `CHK("opcode", 8'ha5, opcode)
    i_sfb_host_model.pins(1'b0, 1'b0, 1'b0, 1'b1, 6);
    `CHK("io_oe paused", 4'h0, io_oe)
    i_sfb_host_model.pins(1'b0, 1'b0, 1'b1, 1'b1, 6);
    `CHK("io_oe back", 4'h2, io_oe)
    i_sfb_host_model.stop();
    $display("t_pause done");
  endtask

  task automatic t_abort();
    int n0;
    i_sfb_host_model.start(1'b0);
    i_sfb_host_model.send_bits(8'h0f, 4);
    i_sfb_host_model.pins(1'b0, 1'b0, 1'b0, 1'b1, 6);
    n0 = n_abort;
    i_sfb_host_model.pins(1'b0, 1'b1, 1'b0, 1'b1, 6);
    `CHK("abort count", n0 + 1, n_abort)
    `CHK("paused after abort", 1'b0, paused)
    i_sfb_host_model.pins(1'b0, 1'b1, 1'b1, 1'b1, 6);
    i_sfb_host_model.start(1'b0);
    i_sfb_host_model.send_bits(CMD_DUAL_OUT, 8);
    i_sfb_host_model.tick(2);
    `CHK("opcode after abort", CMD_DUAL_OUT, opcode)
    i_sfb_host_model.stop();
    $display("t_abort done");
  endtask

  task automatic t_reset();
    int n0;
    pin_func_rst   <= 1'b1;
    n0 = n_hwrst;
    i_sfb_host_model.pins(1'b0, 1'b1, 1'b0, 1'b1, 10);
    i_sfb_host_model.pins(1'b0, 1'b1, 1'b1, 1'b1, 6);
    `CHK("short reset", n0, n_hwrst)
    i_sfb_host_model.pins(1'b0, 1'b1, 1'b0, 1'b1, 24);
    i_sfb_host_model.pins(1'b0, 1'b1, 1'b1, 1'b1, 6);
    `CHK("shared reset", n0 + 1, n_hwrst)
    wide_io_enable <= 1'b1;
    i_sfb_host_model.pins(1'b0, 1'b1, 1'b0, 1'b1, 24);
    i_sfb_host_model.pins(1'b0, 1'b1, 1'b1, 1'b1, 6);
    `CHK("shared reset off", n0 + 1, n_hwrst)
    i_sfb_host_model.start(1'b0);
    i_sfb_host_model.send_bits(CMD_QUAD_IO, 8);
    i_sfb_host_model.send_bits(8'h00, 1);
    i_sfb_host_model.pins(1'b0, 1'b0, 1'b1, 1'b0, 24);
    i_sfb_host_model.pins(1'b0, 1'b0, 1'b1, 1'b1, 6);
    `CHK("dedicated reset", n0 + 2, n_hwrst)
    `CHK("io_oe standby", 4'h0, io_oe)
    `CHK("lane after reset", SFB_LANE_1, lane_mode)
    i_sfb_host_model.stop();
    $display("t_reset done");
  endtask

  initial begin
    clk            = 1'b0;
    sys_rst        = 1'b1;
    wide_io_enable = 1'b0;
    pin_func_rst   = 1'b0;
    tx_nibble      = 4'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("io_oe reset", 4'h0, io_oe)
    t_mode(1'b0);
    t_mode(1'b1);
    t_lanes();
    t_pause();
    t_abort();
    t_reset();
    end_of_test();
  end
endmodule // testbench
